// ---- hw/shrc_top.v ----
// serial host port and radio state control of the transceiver
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
`include "shrc_defines.vh"

module shrc_top #(
  parameter FIFO_AW = 6
) (
  // system clock and reset
  input wire pclk,
  input wire presetn,
  // apb register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // serial host port pins
  input wire sclk,
  input wire sdi,
  input wire serial_select_n,
  output reg sdo,
  output wire sdo_oe,
  // power pins
  input wire reset_pin_n,
  input wire regulator_power_down_pin,
  // radio datapath events
  input wire tx_done_evt,
  input wire rx_done_evt,
  input wire wake_timer_evt,
  input wire resleep_timer_evt,
  input wire cca_done_evt,
  input wire cca_busy,
  input wire cal_done_evt,
  input wire pll_unlock_evt,
  // state and power outputs
  output reg [3:0] radio_state_code,
  output reg main_regulator_on,
  output reg sub_regulator_on,
  output reg main_osc_on,
  output reg slow_osc_on,
  output reg low_timer_on,
  output reg power_down_enable,
  output reg wake_timer_clock_select
);

  localparam DEPTH = 1 << FIFO_AW;
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_TX = 5'h02;
  localparam [4:0] ST_RX = 5'h04;
  localparam [4:0] ST_SLEEP = 5'h08;
  localparam [4:0] ST_CAL = 5'h10;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [2:0] sclk_s;
  reg [1:0] sdi_s;
  reg [2:0] csn_s;
  reg [1:0] rpin_s;
  reg [1:0] pdpin_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s <= 3'h0;
      sdi_s <= 2'h0;
      csn_s <= 3'h7;
      rpin_s <= 2'h3;
      pdpin_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      sdi_s <= {sdi_s[0], sdi};
      csn_s <= {csn_s[1:0], serial_select_n};
      rpin_s <= {rpin_s[0], reset_pin_n};
      pdpin_s <= {pdpin_s[0], regulator_power_down_pin};
    end
  end

  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_act = ~csn_s[1];
  wire cs_end = csn_s[1] & ~csn_s[2];
  wire pin_clr = ~rpin_s[1];
  wire deep_sleep = ~rpin_s[1] & pdpin_s[1];

  ////////////////////////////////////////////////////////////////////////
  // registers and fifo storage
  reg bank_q;
  reg [7:0] trig_q;
  reg [7:0] clk_q;
  reg [7:0] auto_q;
  reg [3:0] cmd_q;
  reg [7:0] sleep_q;
  reg [7:0] cca_q;
  reg [7:0] ed_q;
  reg [7:0] cal_q;
  reg [7:0] lock_q;
  reg [7:0] fifo_mem [0:DEPTH-1];
  reg [FIFO_AW-1:0] wp_q;
  reg [FIFO_AW-1:0] rp_q;
  reg [FIFO_AW:0] cnt_q;
  reg [4:0] st_q;
  reg [4:0] st_d;
  reg [4:0] after_cal_q;
  reg [4:0] after_cal_d;

  function [7:0] rd_byte;
    input [6:0] a;
    input bank;
    begin
      rd_byte = 8'h00;
      if (a == `SHRC_A_BANK)
        rd_byte = {7'h00, bank};
      else if (bank) begin
        if (a == `SHRC_A1_LOCK)
          rd_byte = lock_q;
      end else begin
        case (a)
          `SHRC_A_TRIG: rd_byte = trig_q;
          `SHRC_A_CLK: rd_byte = clk_q;
          `SHRC_A_AUTO: rd_byte = auto_q;
          `SHRC_A_STATE: rd_byte = {radio_state_code, cmd_q};
          `SHRC_A_SLEEP: rd_byte = sleep_q;
          `SHRC_A_CCA: rd_byte = cca_q;
          `SHRC_A_ED: rd_byte = ed_q;
          `SHRC_A_CAL: rd_byte = cal_q;
          `SHRC_A_RXF: rd_byte = fifo_mem[rp_q];
          default: rd_byte = 8'h00;
        endcase
      end
    end
  endfunction

  function mapped;
    input [6:0] a;
    input bank;
    begin
      if (bank)
        mapped = (a == `SHRC_A_BANK) | (a == `SHRC_A1_LOCK);
      else
        case (a)
          `SHRC_A_BANK, `SHRC_A_TRIG, `SHRC_A_CLK, `SHRC_A_AUTO,
          `SHRC_A_STATE, `SHRC_A_SLEEP, `SHRC_A_CCA, `SHRC_A_ED,
          `SHRC_A_CAL, `SHRC_A_TXF, `SHRC_A_RXF: mapped = 1'b1;
          default: mapped = 1'b0;
        endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial slave, sampled by pclk
  reg [6:0] sh_in_q;
  reg [2:0] bit_q;
  reg have_cmd_q;
  reg spi_rw_q;
  reg [6:0] spi_addr_q;
  reg [7:0] sh_out_q;
  reg fifo_touch_q;
  reg spi_we;
  reg spi_pop;
  reg [7:0] in_byte_q;

  wire last_bit = sclk_rise & (bit_q == 3'h7) & cs_act;
  wire [7:0] in_byte = {sh_in_q, sdi_s[1]};
  wire addr_fixed = (spi_addr_q == `SHRC_A_TXF) |
                    (spi_addr_q == `SHRC_A_RXF);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_in_q <= 7'h00;
      bit_q <= 3'h0;
      have_cmd_q <= 1'b0;
      spi_rw_q <= 1'b0;
      spi_addr_q <= 7'h00;
      sh_out_q <= 8'h00;
      sdo <= 1'b0;
      fifo_touch_q <= 1'b0;
      spi_we <= 1'b0;
      spi_pop <= 1'b0;
    end else begin
      spi_we <= 1'b0;
      spi_pop <= 1'b0;
      if (spi_we && !addr_fixed)
        spi_addr_q <= spi_addr_q + 7'h01;
      if (!cs_act) begin
        bit_q <= 3'h0;
        have_cmd_q <= 1'b0;
        if (cs_end)
          fifo_touch_q <= 1'b0;
      end else if (sclk_rise) begin
        sh_in_q <= in_byte[6:0];
        bit_q <= bit_q + 3'h1;
        if (last_bit) begin
          if (!have_cmd_q) begin
            have_cmd_q <= 1'b1;
            spi_addr_q <= in_byte[7:1];
            spi_rw_q <= in_byte[0];
            if (!in_byte[0]) begin
              sh_out_q <= rd_byte(in_byte[7:1], bank_q);
              sdo <= |(rd_byte(in_byte[7:1], bank_q) & 8'h80);
              spi_pop <= (in_byte[7:1] == `SHRC_A_RXF) & ~bank_q;
            end
          end else begin
            if (!addr_fixed && !spi_rw_q)
              spi_addr_q <= spi_addr_q + 7'h01;
            if (spi_rw_q) begin
              spi_we <= 1'b1;
              if (spi_addr_q == `SHRC_A_TXF)
                fifo_touch_q <= 1'b1;
            end else begin
              sh_out_q <= rd_byte(spi_addr_q + (addr_fixed ? 7'h00 :
                          7'h01), bank_q);
              sdo <= |(rd_byte(spi_addr_q + (addr_fixed ? 7'h00 :
                     7'h01), bank_q) & 8'h80);
              spi_pop <= (spi_addr_q == `SHRC_A_RXF) & ~bank_q;
            end
          end
        end
      end else if (sclk_fall && bit_q != 3'h0) begin
        sh_out_q <= {sh_out_q[6:0], 1'b0};
        sdo <= sh_out_q[6];
      end
    end
  end

  assign sdo_oe = cs_act & have_cmd_q & ~spi_rw_q;

  ////////////////////////////////////////////////////////////////////////
  // apb slave; held off while a serial write or pop commits
  wire [6:0] apb_idx = paddr[8:2];
  wire apb_ok = mapped(apb_idx, bank_q) & (paddr[11:9] == 3'h0) &
                (paddr[1:0] == 2'h0);
  wire apb_acc = psel & penable & pready;

  assign pready = ~(spi_we | spi_pop);
  assign pslverr = psel & penable & ~apb_ok;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= {24'h000000, apb_ok ? rd_byte(apb_idx, bank_q) : 8'h00};
  end

  wire apb_we = apb_acc & pwrite & apb_ok;
  wire apb_pop = apb_acc & ~pwrite & apb_ok & ~bank_q &
                 (apb_idx == `SHRC_A_RXF);
  wire we = spi_we | apb_we;
  wire [6:0] wa = spi_we ? spi_addr_q : apb_idx;
  wire [7:0] wd = spi_we ? in_byte_q : pwdata[7:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      in_byte_q <= 8'h00;
    else if (last_bit)
      in_byte_q <= in_byte;
  end

  wire w0 = we & ~bank_q;
  wire cmd_wr = w0 & (wa == `SHRC_A_STATE);
  wire push = w0 & (wa == `SHRC_A_TXF) & ~cnt_q[FIFO_AW];
  wire pop = (spi_pop | apb_pop) & (cnt_q != 0);

  ////////////////////////////////////////////////////////////////////////
  // autonomous transmit triggers
  wire can_go_tx = (st_q == ST_IDLE) | (st_q == ST_RX);
  wire auto_tx = cs_end & fifo_touch_q & auto_q[`SHRC_B_AUTO_TX];
  wire fast_tx = auto_q[`SHRC_B_FAST_TX] &
                 ({1'b0, cnt_q} > {1'b0, trig_q} + 9'h001);

  function [4:0] done_state;
    input [1:0] sel;
    begin
      case (sel)
        `SHRC_DONE_RX: done_state = ST_RX;
        `SHRC_DONE_TX: done_state = ST_TX;
        `SHRC_DONE_SLEEP: done_state = ST_SLEEP;
        default: done_state = ST_IDLE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // radio state machine
  always @* begin
    st_d = st_q;
    after_cal_d = after_cal_q;
    case (st_q)
      ST_TX: begin
        if (pll_unlock_evt && lock_q[`SHRC_B_UNLOCK])
          st_d = ST_IDLE;
        else if (tx_done_evt)
          st_d = done_state(auto_q[1:0]);
        else if (resleep_timer_evt && sleep_q[`SHRC_B_RESLEEP])
          st_d = ST_SLEEP;
      end
      ST_RX: begin
        if (rx_done_evt)
          st_d = done_state(auto_q[3:2]);
        else if (cca_done_evt && !cca_busy && ed_q[`SHRC_B_CCA_SEND])
          st_d = ST_TX;
        else if (cca_done_evt && cca_q[`SHRC_B_QUICK_SLEEP])
          st_d = ST_SLEEP;
        else if (resleep_timer_evt && sleep_q[`SHRC_B_RESLEEP])
          st_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!sleep_q[`SHRC_B_SLEEP_GO])
          st_d = ST_IDLE;
        else if (wake_timer_evt && sleep_q[`SHRC_B_WAKE_EN]) begin
          after_cal_d = sleep_q[`SHRC_B_WAKE_DIR] ? ST_TX : ST_RX;
          st_d = cal_q[`SHRC_B_CAL_WAKE] ? ST_CAL : after_cal_d;
        end
      end
      ST_CAL: begin
        if (cal_done_evt)
          st_d = after_cal_q;
      end
      default: st_d = ST_IDLE;
    endcase
    if (st_q == ST_IDLE && cal_q[`SHRC_B_CAL_GO]) begin
      st_d = ST_CAL;
      after_cal_d = ST_IDLE;
    end
    if (can_go_tx && (auto_tx || fast_tx))
      st_d = ST_TX;
    if (st_q != ST_SLEEP && sleep_q[`SHRC_B_SLEEP_GO])
      st_d = ST_SLEEP;
    if (cmd_wr) begin
      if (wd[3:0] == `SHRC_CMD_FOFF)
        st_d = ST_IDLE;
      else if (st_q != ST_SLEEP && st_q != ST_CAL) begin
        if (wd[3:0] == `SHRC_CMD_TX)
          st_d = ST_TX;
        else if (wd[3:0] == `SHRC_CMD_RX)
          st_d = ST_RX;
        else if (wd[3:0] == `SHRC_CMD_OFF)
          st_d = ST_IDLE;
      end
    end
  end

  wire to_sleep = (st_d == ST_SLEEP) & (st_q != ST_SLEEP);
  wire woke = (st_q == ST_SLEEP) & (st_d != ST_SLEEP);
  wire cal_end = (st_q == ST_CAL) & (st_d != ST_CAL);

  ////////////////////////////////////////////////////////////////////////
  // register file, fifo and state update
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= 1'b0;
      trig_q <= `SHRC_RST_TRIG;
      clk_q <= `SHRC_RST_BYTE;
      auto_q <= `SHRC_RST_BYTE;
      cmd_q <= 4'h0;
      sleep_q <= `SHRC_RST_BYTE;
      cca_q <= `SHRC_RST_BYTE;
      ed_q <= `SHRC_RST_BYTE;
      cal_q <= `SHRC_RST_BYTE;
      lock_q <= `SHRC_RST_BYTE;
      wp_q <= {FIFO_AW{1'b0}};
      rp_q <= {FIFO_AW{1'b0}};
      cnt_q <= {(FIFO_AW+1){1'b0}};
      st_q <= ST_IDLE;
      after_cal_q <= ST_IDLE;
    end else if (pin_clr) begin
      bank_q <= 1'b0;
      trig_q <= `SHRC_RST_TRIG;
      clk_q <= `SHRC_RST_BYTE;
      auto_q <= `SHRC_RST_BYTE;
      cmd_q <= 4'h0;
      sleep_q <= `SHRC_RST_BYTE;
      cca_q <= `SHRC_RST_BYTE;
      ed_q <= `SHRC_RST_BYTE;
      cal_q <= `SHRC_RST_BYTE;
      lock_q <= `SHRC_RST_BYTE;
      wp_q <= {FIFO_AW{1'b0}};
      rp_q <= {FIFO_AW{1'b0}};
      cnt_q <= {(FIFO_AW+1){1'b0}};
      st_q <= ST_IDLE;
      after_cal_q <= ST_IDLE;
    end else begin
      if (we && wa == `SHRC_A_BANK)
        bank_q <= wd[0];
      if (we && bank_q && wa == `SHRC_A1_LOCK)
        lock_q <= wd;
      if (w0) begin
        case (wa)
          `SHRC_A_TRIG: trig_q <= wd;
          `SHRC_A_CLK: clk_q <= wd;
          `SHRC_A_AUTO: auto_q <= wd;
          `SHRC_A_STATE: cmd_q <= wd[3:0];
          `SHRC_A_SLEEP: sleep_q <= wd;
          `SHRC_A_CCA: cca_q <= wd;
          `SHRC_A_ED: ed_q <= wd;
          `SHRC_A_CAL: cal_q <= wd;
          default: ;
        endcase
      end
      // hardware changes after software writes, so they win
      if (to_sleep)
        sleep_q[`SHRC_B_SLEEP_GO] <= 1'b1;
      if (woke && sleep_q[`SHRC_B_SLEEP_GO])
        sleep_q[`SHRC_B_SLEEP_GO] <= 1'b0;
      if (cal_end)
        cal_q[`SHRC_B_CAL_GO] <= 1'b0;
      st_q <= st_d;
      after_cal_q <= after_cal_d;
      if (to_sleep) begin
        wp_q <= {FIFO_AW{1'b0}};
        rp_q <= {FIFO_AW{1'b0}};
        cnt_q <= {(FIFO_AW+1){1'b0}};
      end else begin
        if (push) begin
          fifo_mem[wp_q] <= wd;
          wp_q <= wp_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
        end
        if (pop)
          rp_q <= rp_q + {{(FIFO_AW-1){1'b0}}, 1'b1};
        if (push && !pop)
          cnt_q <= cnt_q + {{FIFO_AW{1'b0}}, 1'b1};
        else if (pop && !push)
          cnt_q <= cnt_q - {{FIFO_AW{1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state code and power outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_state_code <= `SHRC_CODE_IDLE;
      main_regulator_on <= 1'b1;
      sub_regulator_on <= 1'b1;
      main_osc_on <= 1'b1;
      slow_osc_on <= 1'b0;
      low_timer_on <= 1'b0;
      power_down_enable <= 1'b0;
      wake_timer_clock_select <= 1'b0;
    end else begin
      case (st_q)
        ST_TX: radio_state_code <= `SHRC_CODE_TX;
        ST_RX: radio_state_code <= `SHRC_CODE_RX;
        ST_SLEEP: radio_state_code <= `SHRC_CODE_SLEEP;
        ST_CAL: radio_state_code <= `SHRC_CODE_CAL;
        default: radio_state_code <= `SHRC_CODE_IDLE;
      endcase
      main_regulator_on <= ~deep_sleep & (st_q != ST_SLEEP);
      main_osc_on <= ~deep_sleep & (st_q != ST_SLEEP);
      sub_regulator_on <= ~deep_sleep;
      slow_osc_on <= ~deep_sleep & clk_q[`SHRC_B_SLOW_OSC];
      low_timer_on <= ~deep_sleep & clk_q[`SHRC_B_SLOW_OSC] &
                      sleep_q[`SHRC_B_WAKE_EN];
      power_down_enable <= sleep_q[`SHRC_B_PDN];
      wake_timer_clock_select <= sleep_q[`SHRC_B_WUT_SRC];
    end
  end

endmodule

// ---- shared/shrc_defines.vh ----
// register map, field positions, codes and reset values of the rf control
`ifndef SHRC_DEFINES_VH
`define SHRC_DEFINES_VH

// bank 0 register indexes; apb byte address is index times four
`define SHRC_A_BANK 7'h00
`define SHRC_A_TRIG 7'h01
`define SHRC_A_CLK 7'h03
`define SHRC_A_AUTO 7'h0A
`define SHRC_A_STATE 7'h0B
`define SHRC_A_SLEEP 7'h2D
`define SHRC_A_CCA 7'h39
`define SHRC_A_ED 7'h41
`define SHRC_A_CAL 7'h6F
`define SHRC_A_TXF 7'h7C
`define SHRC_A_RXF 7'h7F
// bank 1 register index
`define SHRC_A1_LOCK 7'h0B

// field positions
`define SHRC_B_SLOW_OSC 3
`define SHRC_B_AUTO_TX 4
`define SHRC_B_FAST_TX 5
`define SHRC_B_SLEEP_GO 0
`define SHRC_B_PDN 1
`define SHRC_B_WUT_SRC 2
`define SHRC_B_WAKE_EN 4
`define SHRC_B_RESLEEP 5
`define SHRC_B_WAKE_DIR 6
`define SHRC_B_CAL_GO 0
`define SHRC_B_CAL_WAKE 4
`define SHRC_B_QUICK_SLEEP 3
`define SHRC_B_CCA_SEND 6
`define SHRC_B_UNLOCK 7

// transceiver command field codes
`define SHRC_CMD_TX 4'h9
`define SHRC_CMD_RX 4'h6
`define SHRC_CMD_OFF 4'h8
`define SHRC_CMD_FOFF 4'h3

// reported radio state codes
`define SHRC_CODE_IDLE 4'h8
`define SHRC_CODE_TX 4'h9
`define SHRC_CODE_RX 4'h6
`define SHRC_CODE_SLEEP 4'hA
`define SHRC_CODE_CAL 4'hC

// after-send and after-receive state select codes
`define SHRC_DONE_IDLE 2'h0
`define SHRC_DONE_RX 2'h1
`define SHRC_DONE_TX 2'h2
`define SHRC_DONE_SLEEP 2'h3

// reset values
`define SHRC_RST_BYTE 8'h00
`define SHRC_RST_TRIG 8'h20

`endif

// ---- test/shrc_host_model.sv ----
// serial bus master standing in for the host controller
`timescale 1ns/100ps
module shrc_host_model (
  // serial pins
  output logic sclk,
  output logic sdi,
  output logic serial_select_n,
  input wire sdo
);
  logic [7:0] rx_q [0:7];
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    serial_select_n = 1'b1;
  end
  // mode 0, msb first; clock idles low outside frames
  task automatic shift_byte(input logic [7:0] tx, input int nbits,
                            output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nbits; i--) begin
      sdi = tx[i];
      #100;
      sclk = 1'b1;
      rx[i] = sdo;
      #100;
      sclk = 1'b0;
    end
    sdi = ~sdi;
  endtask
  // command byte then n data bytes; last byte cut to last_bits
  task automatic frame(input logic [6:0] addr, input logic wr,
                       input logic [63:0] data, input int n,
                       input int last_bits);
    logic [7:0] dummy;
    serial_select_n = 1'b0;
    #100;
    shift_byte({addr, wr}, 8, dummy);
    for (int k = 0; k < n; k++)
      shift_byte(data[63 - 8 * k -: 8], (k == n - 1) ? last_bits : 8,
                 rx_q[k]);
    #100;
    serial_select_n = 1'b1;
    #300;
  endtask
endmodule

// ---- test/shrc_top_sva.sv ----
// assertion checker bound to the rf control top
`timescale 1ns/100ps
`include "shrc_defines.vh"
module shrc_top_sva #(
  parameter FIFO_AW = 6
) (
  // clock, reset, apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // serial and power pins
  input wire serial_select_n,
  input wire sdo_oe,
  input wire reset_pin_n,
  input wire regulator_power_down_pin,
  // state and power outputs
  input wire [3:0] radio_state_code,
  input wire main_regulator_on,
  input wire sub_regulator_on,
  input wire main_osc_on,
  input wire slow_osc_on,
  input wire low_timer_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_reset_idle: assert property ($rose(presetn) |->
    radio_state_code == `SHRC_CODE_IDLE && main_osc_on)
    else $error("state not idle after reset");
  a_code_legal: assert property (radio_state_code inside
    {4'h8, 4'h9, 4'h6, 4'hA, 4'hC})
    else $error("illegal state code");
  a_sleep_power: assert property ((radio_state_code == 4'hA)[*2] |->
    !main_regulator_on && !main_osc_on && sub_regulator_on)
    else $error("power wrong in sleep");
  a_wake_osc: assert property ($fell(radio_state_code == 4'hA) |->
    ##[0:2] main_osc_on)
    else $error("oscillator off after wake");
  a_deep_sleep: assert property ((!reset_pin_n &&
    regulator_power_down_pin)[*5] |-> !sub_regulator_on)
    else $error("sub regulator on in deep sleep");
  a_deep_all_off: assert property (!sub_regulator_on |->
    !main_regulator_on && !slow_osc_on && !low_timer_on)
    else $error("supply on in deep sleep");
  a_timer_osc: assert property (low_timer_on |-> slow_osc_on)
    else $error("low timer without slow oscillator");
  a_oe_select: assert property (serial_select_n[*4] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  a_ready_wait: assert property (!pready |=> pready)
    else $error("more than one apb wait");
  a_rdata_hold: assert property (psel && penable && !pready |=>
    $stable(prdata))
    else $error("read data moved in wait");
  a_err_data: assert property (pslverr |-> psel && penable &&
    prdata == 32'h0)
    else $error("error response with data");
endmodule
////////////////////////////////////////////////////////////////////////
bind shrc_top shrc_top_sva #(.FIFO_AW(FIFO_AW)) u_shrc_top_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_select_n(serial_select_n), .sdo_oe(sdo_oe),
  .reset_pin_n(reset_pin_n),
  .regulator_power_down_pin(regulator_power_down_pin),
  .radio_state_code(radio_state_code),
  .main_regulator_on(main_regulator_on),
  .sub_regulator_on(sub_regulator_on), .main_osc_on(main_osc_on),
  .slow_osc_on(slow_osc_on), .low_timer_on(low_timer_on));

// ---- test/shrc_top_test.sv ----
// self-checking bench for the rf control top
`timescale 1ns/100ps
`include "shrc_defines.vh"
module shrc_top_test;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic reset_pin_n, regulator_power_down_pin, cca_busy;
  logic [6:0] evt;
  wire [31:0] prdata;
  wire pready, pslverr, sclk, sdi, serial_select_n, sdo, sdo_oe;
  wire [3:0] radio_state_code;
  wire [6:0] pwr;
  // released data line shows the inverse of the last value
  wire sdo_pin = sdo_oe ? sdo : ~sdo;
  int bad_count = 0;
  int checks_done = 0;
  shrc_top u_shrc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk(sclk), .sdi(sdi),
    .serial_select_n(serial_select_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .reset_pin_n(reset_pin_n),
    .regulator_power_down_pin(regulator_power_down_pin),
    .tx_done_evt(evt[0]), .rx_done_evt(evt[1]), .wake_timer_evt(evt[2]),
    .resleep_timer_evt(evt[3]), .cca_done_evt(evt[4]),
    .cca_busy(cca_busy), .cal_done_evt(evt[5]), .pll_unlock_evt(evt[6]),
    .radio_state_code(radio_state_code),
    .main_regulator_on(pwr[6]), .sub_regulator_on(pwr[5]),
    .main_osc_on(pwr[4]), .slow_osc_on(pwr[3]), .low_timer_on(pwr[2]),
    .power_down_enable(pwr[1]), .wake_timer_clock_select(pwr[0]));
  shrc_host_model u_shrc_host_model (
    .sclk(sclk), .sdi(sdi), .serial_select_n(serial_select_n),
    .sdo(sdo_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits for pready, bounded
  task automatic apb(input logic wr, input logic [6:0] idx,
                     input logic [7:0] wd);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {3'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    while (!ok) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      n++;
      if (n > 20) begin
        bad_count++;
        final_report;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  task automatic wait_code(input logic [3:0] exp);
    int n;
    n = 0;
    while (radio_state_code !== exp && n < 100) begin
      @(posedge pclk);
      n++;
    end
    #1;
    check({28'h0, radio_state_code}, {28'h0, exp});
    if (radio_state_code !== exp)
      final_report;
  endtask
  task automatic pulse(input int i);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt[i] <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    final_report;
  end
  initial begin
    logic [3:0] cmds [0:4];
    logic [3:0] codes [0:4];
    cmds = '{4'h9, 4'h6, 4'h8, 4'h9, 4'h3};
    codes = '{4'h9, 4'h6, 4'h8, 4'h9, 4'h8};
    {presetn, psel, penable, pwrite, err} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {reset_pin_n, regulator_power_down_pin, cca_busy, evt} = 10'h200;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(`SHRC_A_TRIG, 8'h20);
    apb(1'b0, 7'h02, 8'h00);
    check({31'h0, err}, 32'h1);
    // serial burst, abort, readback, fifo stream
    u_shrc_host_model.frame(7'h00, 1'b1, {8'h00, 8'h5A, 48'h0}, 2, 8);
    rdc(`SHRC_A_TRIG, 8'h5A);
    u_shrc_host_model.frame(7'h01, 1'b1, {8'hA5, 56'h0}, 1, 5);
    rdc(`SHRC_A_TRIG, 8'h5A);
    u_shrc_host_model.frame(7'h01, 1'b0, 64'h0, 1, 8);
    check({24'h0, u_shrc_host_model.rx_q[0]}, 32'h5A);
    u_shrc_host_model.frame(7'h7C, 1'b1, {16'h1122, 48'h0}, 2, 8);
    u_shrc_host_model.frame(7'h7F, 1'b0, 64'h0, 2, 8);
    check({24'h0, u_shrc_host_model.rx_q[0]}, 32'h11);
    check({24'h0, u_shrc_host_model.rx_q[1]}, 32'h22);
    // commands, each after the previous state settled
    for (int i = 0; i < 5; i++) begin
      wr(`SHRC_A_STATE, {4'h0, cmds[i]});
      wait_code(codes[i]);
    end
    wr(`SHRC_A_AUTO, 8'h10);
    u_shrc_host_model.frame(7'h7C, 1'b1, {8'h33, 56'h0}, 1, 8);
    wait_code(`SHRC_CODE_TX);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_FOFF});
    wait_code(`SHRC_CODE_IDLE);
    // done selects: send then receive, receive then sleep
    wr(`SHRC_A_AUTO, 8'h0D);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_TX});
    wait_code(`SHRC_CODE_TX);
    pulse(0);
    wait_code(`SHRC_CODE_RX);
    pulse(1);
    wait_code(`SHRC_CODE_SLEEP);
    rdc(`SHRC_A_SLEEP, 8'h01);
    wr(`SHRC_A_SLEEP, 8'h00);
    wait_code(`SHRC_CODE_IDLE);
    wr(`SHRC_A_AUTO, 8'h00);
    // untimed sleep
    wr(`SHRC_A_SLEEP, 8'h07);
    wait_code(`SHRC_CODE_SLEEP);
    repeat (3) @(posedge pclk);
    check({25'h0, pwr}, 32'h23);
    wr(`SHRC_A_SLEEP, 8'h00);
    wait_code(`SHRC_CODE_IDLE);
    // timed sleep, wake through calibration, timed resleep
    wr(`SHRC_A_CLK, 8'h08);
    wr(`SHRC_A_CAL, 8'h10);
    wr(`SHRC_A_SLEEP, 8'h37);
    wait_code(`SHRC_CODE_SLEEP);
    repeat (3) @(posedge pclk);
    check({25'h0, pwr}, 32'h2F);
    pulse(2);
    wait_code(`SHRC_CODE_CAL);
    pulse(5);
    repeat (5) @(posedge pclk);
    check({31'h0, radio_state_code === 4'h9 ||
           radio_state_code === 4'h6}, 32'h1);
    pulse(3);
    wait_code(`SHRC_CODE_SLEEP);
    wr(`SHRC_A_SLEEP, 8'h00);
    wait_code(`SHRC_CODE_IDLE);
    wr(`SHRC_A_CAL, 8'h00);
    wr(`SHRC_A_CLK, 8'h00);
    // calibration by command
    wr(`SHRC_A_CAL, 8'h01);
    wait_code(`SHRC_CODE_CAL);
    pulse(5);
    wait_code(`SHRC_CODE_IDLE);
    rdc(`SHRC_A_CAL, 8'h00);
    // unlock abort in bank 1
    wr(`SHRC_A_BANK, 8'h01);
    wr(`SHRC_A1_LOCK, 8'h80);
    rdc(`SHRC_A1_LOCK, 8'h80);
    wr(`SHRC_A_BANK, 8'h00);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_TX});
    wait_code(`SHRC_CODE_TX);
    pulse(6);
    wait_code(`SHRC_CODE_IDLE);
    // carrier check then send
    wr(`SHRC_A_ED, 8'h40);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_RX});
    wait_code(`SHRC_CODE_RX);
    pulse(4);
    wait_code(`SHRC_CODE_TX);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_OFF});
    wait_code(`SHRC_CODE_IDLE);
    rdc(`SHRC_A_TRIG, 8'h5A);
    // fast transmit past the trigger level, then quick carrier sleep
    wr(`SHRC_A_TRIG, 8'h01);
    wr(`SHRC_A_AUTO, 8'h20);
    u_shrc_host_model.frame(7'h7C, 1'b1, {24'h010203, 40'h0}, 3, 8);
    wait_code(`SHRC_CODE_TX);
    wr(`SHRC_A_AUTO, 8'h00);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_FOFF});
    wait_code(`SHRC_CODE_IDLE);
    wr(`SHRC_A_CCA, 8'h08);
    wr(`SHRC_A_STATE, {4'h0, `SHRC_CMD_RX});
    wait_code(`SHRC_CODE_RX);
    cca_busy <= 1'b1;
    pulse(4);
    wait_code(`SHRC_CODE_SLEEP);
    wr(`SHRC_A_SLEEP, 8'h00);
    wait_code(`SHRC_CODE_IDLE);
    // deep sleep loses registers
    reset_pin_n <= 1'b0;
    regulator_power_down_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    check({31'h0, pwr[5]}, 32'h0);
    reset_pin_n <= 1'b1;
    regulator_power_down_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rdc(`SHRC_A_TRIG, 8'h20);
    final_report;
  end
endmodule
